// ==== core/otf_tx_framer.sv ====
// otuk transmit framer: overhead insertion and payload byte stream
// ==========================================================
`timescale 1ns/100ps
`include "otf_defines.svh"
module otf_tx_framer #(
	parameter int ROW_BYTES = `OTF_ROW_BYTES
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_tx_en,
	input  wire logic [5:0]             i_fas_ovr_en,
	input  wire logic [47:0]            i_fas_val,
	input  wire logic [3:0]             i_sm_bei,
	input  wire logic                   i_sm_biae,
	input  wire logic                   i_sm_bdi,
	input  wire logic                   i_sm_iae,
	input  wire logic [23:0]            i_tcm_bei,
	input  wire logic [5:0]             i_tcm_biae,
	input  wire logic [5:0]             i_tcm_bdi,
	input  wire logic [17:0]            i_tcm_stat,
	input  wire logic [15:0]            i_gcc0,
	input  wire logic [15:0]            i_gcc1,
	input  wire logic [15:0]            i_gcc2,
	input  wire otf_pkg::otf_client_t   i_client_sel,
	input  wire logic                   i_tti_wr,
	input  wire logic [2:0]             i_tti_sel,
	input  wire logic [5:0]             i_tti_addr,
	input  wire logic [7:0]             i_tti_data,
	input  wire otf_pkg::otf_rate_t     i_line_rate,
	input  wire otf_pkg::otf_mux_t      i_mux_kind,
	input  wire logic [6:0]             i_ts_count,
	input  wire logic                   i_mux3_en,
	output logic      [7:0]             o_tx_data,
	output logic                        o_tx_valid,
	output logic                        o_frame_start,
	output logic      [7:0]             o_mfas,
	output logic                        o_map_ok,
	output logic                        o_ts_2g5
);
	// ==========================================================
	// elaboration checks
	if (ROW_BYTES < 17 || ROW_BYTES > 4096) begin : g_bad_row
		$error("otf_tx_framer: ROW_BYTES must lie in 17..4096");
	end

	localparam logic [11:0] LAST_COL = 12'(ROW_BYTES - 1);

	typedef struct packed {
		logic [1:0]             row;
		logic [11:0]            col;
		logic [1:0]             orow;
		logic [11:0]            ocol;
		logic [7:0]             mfas;
		logic [47:0]            fas;
		logic [7:0]             sm3;
		logic [47:0]            tcm3;
		logic [47:0]            gcc;
		logic                   null_pay;
		logic [6:0][63:0][7:0]  tti;
		logic [7:0]             data;
		logic                   valid;
		logic                   fs;
		logic                   map_ok;
		logic                   ts2g5;
	} otf_state_t;

	otf_state_t  st_q;
	otf_state_t  st_d;
	logic [7:0]  prbs_byte;
	logic [7:0]  bip_byte;
	logic [47:0] tcm3_new;
	logic [7:0]  out_b;
	logic        last;
	logic        emit;
	logic [1:0]  tr;
	logic [11:0] tc;
	logic [6:0]  ts_max;

	// codes above eight would read as zero anyway; sending zero keeps 1011 unambiguous
	function automatic logic [3:0] bei_code(input logic [3:0] bei, input logic biae);
		if (biae) begin
			return `OTF_BIAE_CODE;
		end
		return (bei > `OTF_BEI_MAX) ? 4'h0 : bei;
	endfunction

	// ==========================================================
	// tandem status bytes
	for (genvar g = 0; g < 6; g++) begin : g_tcm
		logic [2:0] stat;
		assign stat = i_tcm_stat[3*g +: 3];
		assign tcm3_new[8*g +: 8] = {bei_code(i_tcm_bei[4*g +: 4], i_tcm_biae[g]),
			i_tcm_bdi[g],
			(stat == `OTF_STAT_RES_A || stat == `OTF_STAT_RES_B) ?
			`OTF_STAT_NOSRC : stat};
	end

	// ==========================================================
	// payload and parity helpers
	assign last = (st_q.row == `OTF_LAST_ROW) && (st_q.col == LAST_COL);
	assign emit = i_tx_en;

	otf_prbs_byte u_prbs (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_adv     (emit && st_q.col >= `OTF_PAY_COL && !st_q.null_pay),
		.o_byte    (prbs_byte)
	);

	otf_bip8 u_bip (
		.i_sys_clk   (i_sys_clk),
		.i_rst_b     (i_rst_b),
		.i_en        (emit && st_q.col >= `OTF_OPU_COL),
		.i_data      (out_b),
		.i_frame_end (emit && last),
		.o_bip       (bip_byte)
	);

	// ==========================================================
	// byte selection
	always_comb begin
		out_b = 8'h00;
		tr = 2'd0;
		tc = 12'd0;
		if (st_q.row == 2'd0) begin
			if (st_q.col < `OTF_FAS_LEN) begin
				out_b = st_q.fas[8*(5 - st_q.col[2:0]) +: 8];
			end else if (st_q.col == `OTF_MFAS_COL) begin
				out_b = st_q.mfas;
			end else if (st_q.col == `OTF_SM_TTI_COL) begin
				out_b = st_q.tti[0][st_q.mfas[5:0]];
			end else if (st_q.col == `OTF_SM_BIP_COL) begin
				out_b = bip_byte;
			end else if (st_q.col == `OTF_SM_B3_COL) begin
				out_b = st_q.sm3;
			end else if (st_q.col == `OTF_GCC0_COL) begin
				out_b = st_q.gcc[47:40];
			end else if (st_q.col == `OTF_GCC0_COL + 12'd1) begin
				out_b = st_q.gcc[39:32];
			end
		end
		if (st_q.row == `OTF_LAST_ROW && st_q.col < 12'd4) begin
			out_b = st_q.gcc[8*(3 - st_q.col[1:0]) +: 8];
		end
		for (int i = 1; i <= 6; i++) begin
			tr = (i <= 3) ? `OTF_TCM_LO_ROW : `OTF_TCM_HI_ROW;
			tc = (i <= 3) ? 12'(`OTF_TCM_LO_BASE - 3*i) : 12'(`OTF_TCM_HI_BASE - 3*i);
			if (st_q.row == tr && st_q.col == tc) begin
				out_b = st_q.tti[i][st_q.mfas[5:0]];
			end else if (st_q.row == tr && st_q.col == tc + 12'd1) begin
				out_b = bip_byte;
			end else if (st_q.row == tr && st_q.col == tc + 12'd2) begin
				out_b = st_q.tcm3[8*(i - 1) +: 8];
			end
		end
		if (st_q.col >= `OTF_PAY_COL) begin
			out_b = st_q.null_pay ? 8'h00 : prbs_byte;
		end
	end

	// ==========================================================
	// mapping legality
	always_comb begin
		case (i_line_rate)
			otf_pkg::otf_rate_otu4: ts_max = `OTF_TS_ODU4;
			otf_pkg::otf_rate_otu3: ts_max = `OTF_TS_ODU3;
			default:                ts_max = `OTF_TS_ODU2;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;
		st_d.valid = 1'b0;
		st_d.fs = 1'b0;
		st_d.map_ok = !(i_mux3_en && i_line_rate == otf_pkg::otf_rate_otu2) &&
			!(i_mux_kind == otf_pkg::otf_mux_flex &&
			(i_ts_count == 7'd0 || i_ts_count > ts_max));
		st_d.ts2g5 = (i_mux_kind == otf_pkg::otf_mux_pt20);
		if (i_tti_wr && i_tti_sel != 3'd7) begin
			st_d.tti[i_tti_sel][i_tti_addr] = i_tti_data;
		end
		if (emit) begin
			st_d.data = out_b;
			st_d.valid = 1'b1;
			st_d.fs = (st_q.row == 2'd0) && (st_q.col == 12'd0);
			st_d.orow = st_q.row;
			st_d.ocol = st_q.col;
			st_d.col = st_q.col + 12'd1;
			if (st_q.col == LAST_COL) begin
				st_d.col = 12'd0;
				st_d.row = st_q.row + 2'd1;
			end
			if (last) begin
				st_d.mfas = st_q.mfas + 8'd1;
				for (int k = 0; k < 6; k++) begin
					st_d.fas[8*(5 - k) +: 8] = i_fas_ovr_en[k] ? i_fas_val[8*(5 - k) +: 8] :
						((k < 3) ? `OTF_FAS_OA1 : `OTF_FAS_OA2);
				end
				st_d.sm3 = {bei_code(i_sm_bei, i_sm_biae), i_sm_bdi, i_sm_iae, 2'b00};
				st_d.tcm3 = tcm3_new;
				st_d.gcc = {i_gcc0, i_gcc1, i_gcc2};
				st_d.null_pay = (i_client_sel == otf_pkg::otf_client_null);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// constants only in the async branch, so reset never depends on logic
			st_q <= '0;
			st_q.fas <= {{3{`OTF_FAS_OA1}}, {3{`OTF_FAS_OA2}}};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_tx_data = st_q.data;
	assign o_tx_valid = st_q.valid;
	assign o_frame_start = st_q.fs;
	assign o_mfas = st_q.mfas;
	assign o_map_ok = st_q.map_ok;
	assign o_ts_2g5 = st_q.ts2g5;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_sm3_out;
		o_tx_valid && st_q.orow == 2'd0 && st_q.ocol == `OTF_SM_B3_COL;
	endsequence

	sequence s_mid_frame;
		!(emit && last);
	endsequence

	a_fas_first: assert property (o_frame_start |-> o_tx_data == st_q.fas[47:40])
		else $error("first frame byte is not the alignment word");
	a_mfas_step: assert property ($changed(o_mfas) |-> o_mfas == 8'($past(o_mfas) + 8'd1))
		else $error("multiframe count did not step by one");
	a_mfas_byte: assert property (o_tx_valid && st_q.orow == 2'd0 &&
		st_q.ocol == `OTF_MFAS_COL |-> o_tx_data == o_mfas)
		else $error("multiframe byte differs from count");
	a_sm3_res: assert property (s_sm3_out |-> o_tx_data[1:0] == 2'b00)
		else $error("reserved status bits not zero");
	a_biae_code: assert property (s_sm3_out and (st_q.sm3[7:4] != `OTF_BIAE_CODE) |->
		o_tx_data[7:4] <= `OTF_BEI_MAX)
		else $error("error count outside 0..8");
	a_tcm_stat: assert property (o_tx_valid && st_q.orow == 2'd2 && st_q.ocol == 12'd8 |->
		o_tx_data[2:0] != `OTF_STAT_RES_A && o_tx_data[2:0] != `OTF_STAT_RES_B)
		else $error("reserved tandem status sent");
	a_bip_slot: assert property (o_tx_valid && st_q.orow == 2'd0 &&
		st_q.ocol == `OTF_SM_BIP_COL |-> o_tx_data == $past(bip_byte))
		else $error("parity byte not from the parity pipe");
	a_pay_null: assert property (o_tx_valid && st_q.ocol >= `OTF_PAY_COL &&
		$past(st_q.null_pay) |-> o_tx_data == 8'h00)
		else $error("null payload carried data");
	a_cfg_hold: assert property (s_mid_frame |=> $stable(st_q.sm3) && $stable(st_q.fas))
		else $error("overhead changed inside a frame");
	a_map_rate: assert property (i_mux3_en && i_line_rate == otf_pkg::otf_rate_otu2 |=>
		!o_map_ok)
		else $error("third stage accepted on otu2");
	a_ts_range: assert property (i_mux_kind == otf_pkg::otf_mux_flex &&
		i_line_rate == otf_pkg::otf_rate_otu2 && i_ts_count > 7'd8 |=> !o_map_ok)
		else $error("slot count above limit accepted");
endmodule

// ==== core/otf_defines.svh ====
// frame geometry, overhead byte positions and reset values of the transmit framer
`ifndef OTF_DEFINES_SVH
`define OTF_DEFINES_SVH

// ==========================================================
// frame geometry
`define OTF_ROW_BYTES    3824
`define OTF_LAST_ROW     2'd3
`define OTF_OPU_COL      12'd14
`define OTF_PAY_COL      12'd16

// ==========================================================
// row 0 overhead columns, zero based
`define OTF_FAS_LEN      12'd6
`define OTF_MFAS_COL     12'd6
`define OTF_SM_TTI_COL   12'd7
`define OTF_SM_BIP_COL   12'd8
`define OTF_SM_B3_COL    12'd9
`define OTF_GCC0_COL     12'd10

// ==========================================================
// tandem field columns: rows 2 and 1, three bytes each; then gcc1 and gcc2 columns of row 3
`define OTF_TCM_LO_ROW   2'd2
`define OTF_TCM_HI_ROW   2'd1
`define OTF_TCM_LO_BASE  9
`define OTF_TCM_HI_BASE  22
`define OTF_GCC1_COL     12'd0
`define OTF_GCC2_COL     12'd2

// ==========================================================
// reset values
`define OTF_FAS_OA1      8'hf6
`define OTF_FAS_OA2      8'h28
`define OTF_PRBS_SEED    31'h7fffffff

// ==========================================================
// trace message layout, backward error codes, tandem status codes and slot count limits
`define OTF_TTI_SAPI     6'd0
`define OTF_TTI_DAPI     6'd16
`define OTF_TTI_OPER     6'd32
`define OTF_BEI_MAX      4'h8
`define OTF_BIAE_CODE    4'hb
`define OTF_STAT_RES_A   3'b011
`define OTF_STAT_RES_B   3'b100
`define OTF_STAT_NOSRC   3'b000
`define OTF_TS_ODU4      7'd80
`define OTF_TS_ODU3      7'd32
`define OTF_TS_ODU2      7'd8

`endif

// ==== core/otf_pkg.sv ====
// types shared by the transmit framer modules
package otf_pkg;

	// ==========================================================
	// configuration selects
	typedef enum logic [1:0] {
		otf_rate_otu2 = 2'h0,
		otf_rate_otu3 = 2'h1,
		otf_rate_otu4 = 2'h3
	} otf_rate_t;

	typedef enum logic [1:0] {
		otf_mux_none = 2'h0,
		otf_mux_flex = 2'h1,
		otf_mux_pt20 = 2'h3,
		otf_mux_pt21 = 2'h2
	} otf_mux_t;

	typedef enum logic {
		otf_client_prbs = 1'b0,
		otf_client_null = 1'b1
	} otf_client_t;

endpackage

// ==== core/otf_prbs_byte.sv ====
// prbs31 payload source, eight bits per advance
`timescale 1ns/100ps
`include "otf_defines.svh"
module otf_prbs_byte (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_adv,
	output logic      [7:0] o_byte
);
	typedef struct packed {
		logic [30:0] lfsr;
	} otf_prbs_st_t;

	otf_prbs_st_t st_q;
	otf_prbs_st_t st_d;
	logic [7:0]   bits;

	// ==========================================================
	// x^31 + x^28 + 1, msb first
	always_comb begin
		st_d = st_q;
		bits = 8'h00;
		for (int k = 0; k < 8; k++) begin
			bits[7 - k] = st_d.lfsr[30] ^ st_d.lfsr[27];
			st_d.lfsr = {st_d.lfsr[29:0], bits[7 - k]};
		end
		if (!i_adv) begin
			st_d = st_q;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '{lfsr: `OTF_PRBS_SEED};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_byte = bits;
endmodule

// ==== core/otf_bip8.sv ====
// bip-8 over the opu area, delivered two frames after the frame it covers
`timescale 1ns/100ps
module otf_bip8 (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_en,
	input  wire logic [7:0] i_data,
	input  wire logic       i_frame_end,
	output logic      [7:0] o_bip
);
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] prev;
		logic [7:0] ins;
	} otf_bip_st_t;

	otf_bip_st_t st_q;
	otf_bip_st_t st_d;
	logic [7:0]  acc_now;

	// ==========================================================
	// even parity per bit column
	always_comb begin
		st_d = st_q;
		acc_now = i_en ? (st_q.acc ^ i_data) : st_q.acc;
		st_d.acc = acc_now;
		if (i_frame_end) begin
			st_d.prev = acc_now;
			st_d.ins  = st_q.prev;
			st_d.acc  = 8'h00;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_bip = st_q.ins;
endmodule

// ==== bench/otf_rx_model.sv ====
// downstream receiver model: frames the byte stream, keeps overhead and parity
`timescale 1ns/100ps
module otf_rx_model #(
	parameter int ROW_BYTES = 17
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_valid,
	input  wire logic       i_fstart,
	input  wire logic [7:0] i_data
);
	// ==========================================================
	// frame capture
	logic [7:0] cur [4][16];
	logic [7:0] oh [4][16];
	logic [7:0] bip_hist [256];
	logic [7:0] bip;
	logic [7:0] pay_or;
	logic [7:0] pay_last;
	int         pos;
	int         nfr;
	// falling edge, so the registered stream has settled
	always @(negedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos = 0;
			nfr = 0;
		end else if (i_valid) begin
			// aligns on the start marker, so an altered word is tolerated
			if (i_fstart) begin
				pos = 0;
				bip = 8'h00;
				pay_or = 8'h00;
			end
			if (pos % ROW_BYTES < 16) cur[pos / ROW_BYTES][pos % ROW_BYTES] = i_data;
			if (pos % ROW_BYTES >= 14) bip = bip ^ i_data;
			if (pos % ROW_BYTES >= 16) pay_or = pay_or | i_data;
			pos++;
			if (pos == 4 * ROW_BYTES) begin
				oh = cur;
				pay_last = pay_or;
				bip_hist[nfr % 256] = bip;
				nfr++;
			end
		end
	end
endmodule

// ==== bench/tb_otuk_overhead_tx_framer.sv ====
// self-checking bench for the transmit framer
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_otuk_overhead_tx_framer;
	localparam int RB = 17;
	logic                 i_sys_clk = 1'b0;
	logic                 i_rst_b, i_tx_en, i_sm_biae, i_sm_bdi, i_sm_iae;
	logic                 i_tti_wr, i_mux3_en, o_tx_valid, o_frame_start, o_map_ok, o_ts_2g5;
	logic [2:0]           i_tti_sel;
	logic [3:0]           i_sm_bei;
	logic [5:0]           i_fas_ovr_en, i_tcm_biae, i_tcm_bdi, i_tti_addr;
	logic [6:0]           i_ts_count;
	logic [7:0]           i_tti_data, o_tx_data, o_mfas;
	logic [15:0]          i_gcc0, i_gcc1, i_gcc2;
	logic [17:0]          i_tcm_stat;
	logic [23:0]          i_tcm_bei;
	logic [47:0]          i_fas_val;
	otf_pkg::otf_client_t i_client_sel;
	otf_pkg::otf_rate_t   i_line_rate;
	otf_pkg::otf_mux_t    i_mux_kind;
	int                   checked, n_mismatch;

	otf_tx_framer #(.ROW_BYTES(RB)) dut (
		.i_sys_clk, .i_rst_b, .i_tx_en, .i_fas_ovr_en, .i_fas_val, .i_sm_bei,
		.i_sm_biae, .i_sm_bdi, .i_sm_iae, .i_tcm_bei, .i_tcm_biae, .i_tcm_bdi,
		.i_tcm_stat, .i_gcc0, .i_gcc1, .i_gcc2, .i_client_sel, .i_tti_wr,
		.i_tti_sel, .i_tti_addr, .i_tti_data, .i_line_rate, .i_mux_kind,
		.i_ts_count, .i_mux3_en, .o_tx_data, .o_tx_valid, .o_frame_start,
		.o_mfas, .o_map_ok, .o_ts_2g5
	);
	otf_rx_model #(.ROW_BYTES(RB)) m (.i_sys_clk, .i_rst_b, .i_valid(o_tx_valid),
		.i_fstart(o_frame_start), .i_data(o_tx_data));

	always #50 i_sys_clk = ~i_sys_clk;

	// ==========================================================
	// helpers
	task tally_and_finish;
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// waits for n whole frames; config set now lands two frames on
	task automatic wf(input int n);
		int t0;
		t0 = m.nfr;
		for (int k = 0; k < 100 * n * RB && m.nfr < t0 + n; k++) @(posedge i_sys_clk);
		if (m.nfr < t0 + n) begin
			n_mismatch++;
			tally_and_finish;
		end
		#1;
	endtask

	task automatic mp(input int r, input int x, input int ts, input int m3, input int e);
		i_line_rate = otf_pkg::otf_rate_t'(2'(r));
		i_mux_kind = otf_pkg::otf_mux_t'(2'(x));
		i_ts_count = 7'(ts);
		i_mux3_en = 1'(m3);
		@(posedge i_sys_clk);
		#1;
		`CHK({o_map_ok, o_ts_2g5}, 2'(e))
	endtask

	// ==========================================================
	// scenarios
	task automatic t_fas;
		wf(1);
		`CHK(m.oh[0][8], 8'h00)
		i_fas_ovr_en = 6'b100001;
		i_fas_val = 48'h010203040506;
		wf(1);
		for (int k = 0; k < 6; k++) `CHK(m.oh[0][k], k < 3 ? 8'hf6 : 8'h28)
		wf(1);
		for (int k = 0; k < 6; k++) `CHK(m.oh[0][k], (k == 0 || k == 5) ? 8'(k + 1) : (k < 3 ? 8'hf6 : 8'h28))
		i_fas_ovr_en = 6'h00;
		$display("fas done");
	endtask

	task automatic t_stat;
		logic [3:0] e;
		logic [2:0] s;
		for (int b = 0; b < 17; b++) begin
			i_sm_bei = 4'(b);
			i_sm_biae = (b == 16);
			i_sm_bdi = b[0];
			i_sm_iae = b[1];
			i_tcm_biae = {6{b == 16}};
			i_tcm_bdi = {6{b[0]}};
			for (int n = 0; n < 6; n++) begin
				i_tcm_bei[4*n+:4] = 4'(b + n);
				i_tcm_stat[3*n+:3] = 3'(b + n);
			end
			wf(2);
			e = (b == 16) ? 4'hb : (4'(b) > 4'h8 ? 4'h0 : 4'(b));
			`CHK(m.oh[0][9], {e, b[0], b[1], 2'b00})
			for (int n = 0; n < 6; n++) begin
				e = (b == 16) ? 4'hb : (4'(b + n) > 4'h8 ? 4'h0 : 4'(b + n));
				s = 3'(b + n);
				if (s == 3'b011 || s == 3'b100) s = 3'b000;
				`CHK(m.oh[n < 3 ? 2 : 1][n < 3 ? 8 - 3*n : 21 - 3*n], {e, b[0], s})
			end
		end
		$display("status done");
	endtask

	task automatic t_gcc;
		i_gcc0 = 16'ha1b2;
		i_gcc1 = 16'hc3d4;
		i_gcc2 = 16'he5f6;
		wf(2);
		`CHK({m.oh[0][10], m.oh[0][11]}, 16'ha1b2)
		`CHK({m.oh[3][0], m.oh[3][1], m.oh[3][2], m.oh[3][3]}, 32'hc3d4e5f6)
		$display("gcc done");
	endtask

	task automatic t_client;
		// a gap in the stream must only pause, not shorten, the frame
		i_tx_en = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_tx_en = 1'b1;
		i_client_sel = otf_pkg::otf_client_null;
		wf(2);
		`CHK(m.pay_last, 8'h00)
		i_client_sel = otf_pkg::otf_client_prbs;
		wf(2);
		`CHK(m.pay_last != 8'h00, 1'b1)
		$display("client done");
	endtask

	task automatic t_map;
		mp(3, 1, 80, 0, 2);
		mp(3, 1, 81, 0, 0);
		mp(1, 1, 32, 0, 2);
		mp(1, 1, 33, 0, 0);
		mp(0, 1, 8, 0, 2);
		mp(0, 1, 9, 0, 0);
		mp(3, 1, 0, 0, 0);
		mp(1, 3, 4, 0, 3);
		mp(1, 2, 4, 0, 2);
		mp(0, 0, 1, 1, 0);
		mp(1, 0, 1, 1, 2);
		mp(3, 0, 1, 1, 2);
		$display("map done");
	endtask

	task automatic t_trace;
		logic [7:0] mf;
		i_tti_wr = 1'b1;
		for (int a = 0; a < 128; a++) begin
			i_tti_sel = 3'(a % 2);
			i_tti_addr = 6'(a / 2);
			i_tti_data = (a % 2 ? 8'h80 : 8'h40) | 8'(a / 2);
			@(posedge i_sys_clk);
			#1;
		end
		// the unused selector must not disturb any trace
		i_tti_sel = 3'd7;
		i_tti_data = 8'h00;
		@(posedge i_sys_clk);
		#1;
		i_tti_wr = 1'b0;
		wf(2);
		mf = m.oh[0][6];
		for (int f = 0; f < 260; f++) begin
			wf(1);
			`CHK(m.oh[0][6], 8'(mf + 8'h01))
			mf = m.oh[0][6];
			`CHK(o_mfas, 8'(mf + 8'h01))
			`CHK(m.oh[0][7], 8'h40 | {2'b00, mf[5:0]})
			`CHK(m.oh[2][6], 8'h80 | {2'b00, mf[5:0]})
			`CHK(m.oh[0][8], m.bip_hist[8'(m.nfr - 3)])
			`CHK(m.oh[1][5], m.oh[0][8])
		end
		$display("trace done");
	endtask

	initial begin
		{i_rst_b, i_sm_biae, i_sm_bdi, i_sm_iae, i_tti_wr, i_mux3_en, i_tti_sel, i_sm_bei} = '0;
		{i_fas_ovr_en, i_tcm_biae, i_tcm_bdi, i_tti_addr, i_ts_count, i_tti_data} = '0;
		{i_gcc0, i_gcc1, i_gcc2, i_tcm_stat, i_tcm_bei, i_fas_val} = '0;
		i_client_sel = otf_pkg::otf_client_prbs;
		i_line_rate = otf_pkg::otf_rate_otu2;
		i_mux_kind = otf_pkg::otf_mux_none;
		i_tx_en = 1'b1;
		checked = 0;
		n_mismatch = 0;
		repeat (6) @(posedge i_sys_clk);
		#1;
		i_rst_b = 1'b1;
		t_fas;
		t_stat;
		t_gcc;
		t_client;
		t_map;
		t_trace;
		tally_and_finish;
	end
endmodule
